/* core/ldo_channel.sv */
`timescale 1ns/1ps
`include "ldo_regs.svh"

module ldo_channel (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // register writes from the decoder
    input wire logic wr_vsel,
    input wire logic wr_ctrl,
    input wire ldo_pkg::reg_byte_t wdata,
    // analog status pins
    input wire logic pg_pin,
    input wire logic fault_pin,
    // regulator controls
    output ldo_pkg::vcode_t output_voltage_code,
    output logic enable,
    output logic discharge,
    // readback and events
    output ldo_pkg::reg_byte_t vsel_byte,
    output ldo_pkg::reg_byte_t ctrl_byte,
    output logic fault_event
);

    // ****************************************************************
    // storage
    // ****************************************************************
    ldo_pkg::vcode_t vcode_reg;
    logic enable_reg;
    logic discharge_enable_reg;
    logic fault_ie_reg;
    logic discharge_reg;
    logic pg_meta_reg;
    logic pg_sync_reg;
    logic fault_meta_reg;
    logic fault_sync_reg;
    logic fault_last_reg;

    // writable fields, reserved bits never stored
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            vcode_reg <= `VCODE_RESET;
            enable_reg <= `CTRL_ENABLE_RESET;
            discharge_enable_reg <= `CTRL_DISCHARGE_RESET;
            fault_ie_reg <= `CTRL_FAULT_IE_RESET;
        end else begin
            if (wr_vsel) begin
                vcode_reg <= wdata[`VCODE_MSB:0];
            end
            if (wr_ctrl) begin
                enable_reg <= wdata[`CTRL_ENABLE_BIT];
                discharge_enable_reg <= wdata[`CTRL_DISCHARGE_BIT];
                fault_ie_reg <= wdata[`CTRL_FAULT_IE_BIT];
            end
        end
    end

    // discharge path only while shut down, and status synchronisers
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            discharge_reg <= 1'b0;
            pg_meta_reg <= 1'b0;
            pg_sync_reg <= 1'b0;
            fault_meta_reg <= 1'b0;
            fault_sync_reg <= 1'b0;
            fault_last_reg <= 1'b0;
        end else begin
            discharge_reg <= discharge_enable_reg & ~enable_reg;
            pg_meta_reg <= pg_pin;
            pg_sync_reg <= pg_meta_reg;
            fault_meta_reg <= fault_pin;
            fault_sync_reg <= fault_meta_reg;
            fault_last_reg <= fault_sync_reg;
        end
    end

    // ****************************************************************
    // outputs and readback
    // ****************************************************************
    assign output_voltage_code = vcode_reg;
    assign enable = enable_reg;
    assign discharge = discharge_reg;
    assign vsel_byte = {2'b00, vcode_reg};
    assign ctrl_byte = {enable_reg, 4'h0, discharge_enable_reg,
                        fault_ie_reg, pg_sync_reg};
    // rising fault, suppressed when the interrupt enable is clear
    assign fault_event = fault_sync_reg & ~fault_last_reg & fault_ie_reg;

    // ****************************************************************
    // checks
    // ****************************************************************
    AST_VSEL_WRITE: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        wr_vsel |=> vsel_byte == {2'b00, $past(wdata[5:0])})
        else $error("voltage code did not take the written value");

    AST_ENABLE_WRITE: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        wr_ctrl |=> enable == $past(wdata[7]))
        else $error("enable did not follow the write");

    AST_DISCHARGE_SHUTDOWN: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (discharge_enable_reg && !enable_reg) |=> discharge)
        else $error("discharge not active in shutdown");

    AST_DISCHARGE_OFF_WHEN_ON: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (enable_reg || !discharge_enable_reg) |=> !discharge)
        else $error("discharge active while on or disabled");

    AST_FAULT_MASKED: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        !fault_ie_reg |-> !fault_event)
        else $error("fault event raised while interrupt disabled");

    AST_POWER_GOOD_TRACK: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        pg_pin [*3] |=> ctrl_byte[0])
        else $error("power good status does not follow the pin");

    COV_FAULT_EVENT: cover property (
        @(posedge sys_clk) disable iff (!rst_n) fault_event);

    COV_DISCHARGE: cover property (
        @(posedge sys_clk) disable iff (!rst_n) $rose(discharge));

endmodule

/* core/ldo_pkg.sv */
package ldo_pkg;

    // one register byte as seen on the register port
    typedef logic [7:0] reg_byte_t;

    // output voltage code of one regulator
    typedef logic [5:0] vcode_t;

    // regulator channels in priority order, a highest
    typedef enum logic [3:0] {
        CH_A = 4'h1,
        CH_B = 4'h2,
        CH_C = 4'h4,
        CH_D = 4'h8
    } channel_t;

endpackage

/* core/ldo_regs.svh */
`ifndef LDO_REGS_SVH
`define LDO_REGS_SVH

// ****************************************************************
// register offsets
// ****************************************************************
`define LDO_A_VOLTAGE_SELECT_ADDR 8'h68
`define LDO_A_CONTROL_ADDR 8'h69
`define LDO_B_VOLTAGE_SELECT_ADDR 8'h70
`define LDO_B_CONTROL_ADDR 8'h71
`define LDO_C_VOLTAGE_SELECT_ADDR 8'h80
`define LDO_C_CONTROL_ADDR 8'h81
`define LDO_D_VOLTAGE_SELECT_ADDR 8'h90
`define LDO_D_CONTROL_ADDR 8'h91
`define INT_SRC_ADDR 8'hc1

// ****************************************************************
// field positions
// ****************************************************************
`define VCODE_MSB 5
`define CTRL_ENABLE_BIT 7
`define CTRL_DISCHARGE_BIT 2
`define CTRL_FAULT_IE_BIT 1
`define CTRL_POWER_GOOD_BIT 0

// ****************************************************************
// reset values
// ****************************************************************
`define VCODE_RESET 6'h00
`define CTRL_ENABLE_RESET 1'h0
`define CTRL_DISCHARGE_RESET 1'h0
`define CTRL_FAULT_IE_RESET 1'h0
`define INT_SRC_IDLE 8'hff
`define RDATA_RESET 8'h00

`endif

/* core/ldo_regulator_control_registers.sv */
`timescale 1ns/1ps
`include "ldo_regs.svh"

// Summary of operation
// - voltage byte: six-bit writable code in bits 5:0, bits 7:6 read-only
// - control bit 7 enables the regulator when one, disables when zero
// - control bit 2 set discharges the output while regulator is shut down
// - control bit 1 lets regulator faults raise interrupts; zero suppresses
// - control bit 0 reads live power-good status, read-only
// - interrupt source holds raising block address; idles at all ones
module ldo_regulator_control_registers (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // byte register port behind the serial interface
    input wire ldo_pkg::reg_byte_t reg_addr,
    input wire logic reg_wr_en,
    input wire logic reg_rd_en,
    input wire ldo_pkg::reg_byte_t reg_wdata,
    output ldo_pkg::reg_byte_t reg_rdata,
    // regulator status pins, a in bit 0 to d in bit 3
    input wire logic [3:0] power_good_in,
    input wire logic [3:0] fault_in,
    // regulator controls
    output logic [3:0] regulator_enable,
    output logic [3:0] discharge_active,
    output ldo_pkg::vcode_t vcode_a,
    output ldo_pkg::vcode_t vcode_b,
    output ldo_pkg::vcode_t vcode_c,
    output ldo_pkg::vcode_t vcode_d,
    // interrupt source holds an address
    output logic interrupt_pending
);

    // ****************************************************************
    // address map
    // ****************************************************************
    localparam logic [31:0] VSEL_ADDRS = {
        `LDO_D_VOLTAGE_SELECT_ADDR,
        `LDO_C_VOLTAGE_SELECT_ADDR,
        `LDO_B_VOLTAGE_SELECT_ADDR,
        `LDO_A_VOLTAGE_SELECT_ADDR
    };
    localparam logic [31:0] CTRL_ADDRS = {
        `LDO_D_CONTROL_ADDR,
        `LDO_C_CONTROL_ADDR,
        `LDO_B_CONTROL_ADDR,
        `LDO_A_CONTROL_ADDR
    };

    logic [3:0] hit_vsel;
    logic [3:0] hit_ctrl;
    logic [3:0] fault_event;
    ldo_pkg::vcode_t vcode [4];
    ldo_pkg::reg_byte_t vsel_byte [4];
    ldo_pkg::reg_byte_t ctrl_byte [4];
    ldo_pkg::reg_byte_t vsel_term [4];
    ldo_pkg::reg_byte_t ctrl_term [4];

    // ****************************************************************
    // regulator channels
    // ****************************************************************
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1) begin : g_ch
            assign hit_vsel[gi] = reg_addr == VSEL_ADDRS[gi*8 +: 8];
            assign hit_ctrl[gi] = reg_addr == CTRL_ADDRS[gi*8 +: 8];
            assign vsel_term[gi] = hit_vsel[gi] ? vsel_byte[gi] : 8'h00;
            assign ctrl_term[gi] = hit_ctrl[gi] ? ctrl_byte[gi] : 8'h00;

            ldo_channel u_channel (
                .sys_clk(sys_clk),
                .rst_n(rst_n),
                .wr_vsel(reg_wr_en & hit_vsel[gi]),
                .wr_ctrl(reg_wr_en & hit_ctrl[gi]),
                .wdata(reg_wdata),
                .pg_pin(power_good_in[gi]),
                .fault_pin(fault_in[gi]),
                .output_voltage_code(vcode[gi]),
                .enable(regulator_enable[gi]),
                .discharge(discharge_active[gi]),
                .vsel_byte(vsel_byte[gi]),
                .ctrl_byte(ctrl_byte[gi]),
                .fault_event(fault_event[gi])
            );
        end
    endgenerate

    assign vcode_a = vcode[0];
    assign vcode_b = vcode[1];
    assign vcode_c = vcode[2];
    assign vcode_d = vcode[3];

    // ****************************************************************
    // interrupt source
    // ****************************************************************
    ldo_pkg::reg_byte_t int_src_reg;
    ldo_pkg::reg_byte_t int_src_next;
    logic [3:0] pend_reg;
    logic [3:0] pend_next;
    logic [3:0] pend_all;
    logic [3:0] pick;
    logic hit_int;
    logic rd_int;
    logic src_idle;
    logic load_now;
    ldo_pkg::reg_byte_t load_addr;

    // events waiting while another address is held
    assign hit_int = reg_addr == `INT_SRC_ADDR;
    assign rd_int = reg_rd_en & hit_int;
    assign src_idle = int_src_reg == `INT_SRC_IDLE;
    assign pend_all = pend_reg | fault_event;

    // lowest channel wins, one-hot pick
    assign pick = pend_all & (~pend_all + 4'h1);
    assign load_now = (|pend_all) & (src_idle | rd_int);

    assign load_addr = pick[0] ?
                       CTRL_ADDRS[7:0] :
                       pick[1] ? CTRL_ADDRS[15:8] :
                       pick[2] ? CTRL_ADDRS[23:16] :
                       CTRL_ADDRS[31:24];

    // a fresh load wins over the clear that a read makes
    assign int_src_next = load_now ? load_addr :
                          rd_int ? `INT_SRC_IDLE : int_src_reg;
    assign pend_next = load_now ? (pend_all & ~pick) : pend_all;

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            int_src_reg <= `INT_SRC_IDLE;
            pend_reg <= 4'h0;
        end else begin
            int_src_reg <= int_src_next;
            pend_reg <= pend_next;
        end
    end

    assign interrupt_pending = !src_idle;

    // ****************************************************************
    // read port
    // ****************************************************************
    ldo_pkg::reg_byte_t rd_mux;
    ldo_pkg::reg_byte_t rdata_reg;

    // unmapped addresses read as zero
    assign rd_mux = vsel_term[0] | vsel_term[1] | vsel_term[2] |
                    vsel_term[3] | ctrl_term[0] | ctrl_term[1] |
                    ctrl_term[2] | ctrl_term[3] |
                    (hit_int ? int_src_reg : 8'h00);

    // read data held until the next read
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            rdata_reg <= `RDATA_RESET;
        end else if (reg_rd_en) begin
            rdata_reg <= rd_mux;
        end
    end

    assign reg_rdata = rdata_reg;

    // ****************************************************************
    // checks
    // ****************************************************************
    AST_INT_READ_RETURNS: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        rd_int |=> reg_rdata == $past(int_src_reg))
        else $error("interrupt source read returned wrong value");

    AST_INT_READ_CLEARS: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (rd_int && !(|pend_all)) |=> int_src_reg == 8'hff)
        else $error("interrupt source not idle after read");

    AST_INT_LOAD: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (src_idle && fault_event[0]) |=> int_src_reg == 8'h69)
        else $error("fault address not captured");

    AST_INT_HOLD: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (!src_idle && !rd_int) |=> int_src_reg == $past(int_src_reg))
        else $error("interrupt source changed without a read");

    AST_VSEL_RSVD_ZERO: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (reg_rd_en && (|hit_vsel)) |=> reg_rdata[7:6] == 2'b00)
        else $error("voltage byte reserved bits not zero");

    AST_CTRL_RSVD_ZERO: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (reg_rd_en && (|hit_ctrl)) |=> reg_rdata[6:3] == 4'h0)
        else $error("control byte reserved bits not zero");

    AST_CTRL_READBACK: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (reg_wr_en && hit_ctrl[1]) ##1 !reg_wr_en ##1
        (reg_rd_en && hit_ctrl[1])
        |=> reg_rdata[7] == $past(reg_wdata[7], 3))
        else $error("enable bit readback mismatch");

    AST_INT_READ_ONLY: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (reg_wr_en && hit_int && src_idle && !(|pend_all)) |=> src_idle)
        else $error("write changed the interrupt source");

    AST_UNMAPPED_ZERO: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (reg_rd_en && !(|hit_vsel) && !(|hit_ctrl) && !hit_int)
        |=> reg_rdata == 8'h00)
        else $error("unmapped address did not read as zero");

    COV_INT_READ: cover property (
        @(posedge sys_clk) disable iff (!rst_n) rd_int && !src_idle);

    COV_QUEUED_FAULT: cover property (
        @(posedge sys_clk) disable iff (!rst_n)
        !src_idle && (|fault_event));

    COV_VSEL_WRITE: cover property (
        @(posedge sys_clk) disable iff (!rst_n)
        reg_wr_en && (|hit_vsel));

endmodule

/* testbench/host_port_model.sv */
`timescale 1ns/1ps

// ****************************************************************
// host side of the byte register port
// ****************************************************************
module host_port_model (
    // clock
    input wire logic sys_clk,
    // register requests
    output ldo_pkg::reg_byte_t reg_addr,
    output logic reg_wr_en,
    output logic reg_rd_en,
    output ldo_pkg::reg_byte_t reg_wdata,
    // read answer
    input wire ldo_pkg::reg_byte_t reg_rdata
);
    // idle port at time zero
    initial begin
        reg_addr = 8'h00;
        reg_wr_en = 1'b0;
        reg_rd_en = 1'b0;
        reg_wdata = 8'h00;
    end

    // one write strobe; released data is inverted so stale bytes show
    task automatic write(input ldo_pkg::reg_byte_t a,
                         input ldo_pkg::reg_byte_t d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr_en <= 1'b1;
        @(posedge sys_clk);
        reg_wr_en <= 1'b0;
        reg_wdata <= ~d;
    endtask

    // one read strobe; answer stands until the next read
    task automatic read(input ldo_pkg::reg_byte_t a,
                        output ldo_pkg::reg_byte_t d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd_en <= 1'b1;
        @(posedge sys_clk);
        reg_rd_en <= 1'b0;
        @(posedge sys_clk);
        #1 d = reg_rdata;
    endtask
endmodule

/* testbench/tb_ldo_regulator_control_registers.sv */
`timescale 1ns/1ps

module tb_ldo_regulator_control_registers;
    // ****************************************************************
    // signals
    // ****************************************************************
    typedef struct {logic [7:0] a; logic [7:0] d; logic [7:0] e;} row_t;
    logic sys_clk;
    logic rst_n;
    ldo_pkg::reg_byte_t reg_addr;
    logic reg_wr_en;
    logic reg_rd_en;
    ldo_pkg::reg_byte_t reg_wdata;
    ldo_pkg::reg_byte_t reg_rdata;
    logic [3:0] power_good_in;
    logic [3:0] fault_in;
    logic [3:0] regulator_enable;
    logic [3:0] discharge_active;
    ldo_pkg::vcode_t vcode_a;
    ldo_pkg::vcode_t vcode_b;
    ldo_pkg::vcode_t vcode_c;
    ldo_pkg::vcode_t vcode_d;
    logic interrupt_pending;
    ldo_pkg::reg_byte_t rd;
    int errors = 0;
    int comparisons = 0;
    // address, written byte, expected readback with power good 4'h5
    row_t rows [9] = '{'{8'h68, 8'hff, 8'h3f}, '{8'h70, 8'hc5, 8'h05},
        '{8'h80, 8'h2a, 8'h2a}, '{8'h90, 8'hff, 8'h3f},
        '{8'h69, 8'hff, 8'h87}, '{8'h71, 8'h04, 8'h04},
        '{8'h81, 8'h82, 8'h83}, '{8'h91, 8'h7b, 8'h02},
        '{8'h55, 8'hff, 8'h00}};

    // ****************************************************************
    // design and host
    // ****************************************************************
    ldo_regulator_control_registers ldo_regulator_control_registers_i (
        .sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .power_good_in(power_good_in), .fault_in(fault_in),
        .regulator_enable(regulator_enable),
        .discharge_active(discharge_active), .vcode_a(vcode_a),
        .vcode_b(vcode_b), .vcode_c(vcode_c), .vcode_d(vcode_d),
        .interrupt_pending(interrupt_pending));

    host_port_model host_port_model_i (
        .sys_clk(sys_clk), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
        .reg_rd_en(reg_rd_en), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata));

    // ****************************************************************
    // helpers
    // ****************************************************************
    // 50 MHz clock
    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end

    task automatic check(input string name, input logic [7:0] seen,
                         input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
        host_port_model_i.read(a, rd);
        check($sformatf("register %h", a), rd, e);
    endtask

    task automatic do_reset();
        @(posedge sys_clk);
        rst_n <= 1'b0;
        repeat (10) @(posedge sys_clk);
        rst_n <= 1'b1;
    endtask

    task automatic close_out();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // watchdog well beyond the expected run of about 150 cycles
    initial begin
        repeat (5000) @(posedge sys_clk);
        errors++;
        $display("watchdog expired");
        close_out();
    end

    // ****************************************************************
    // tests
    // ****************************************************************
    initial begin
        rst_n = 1'b0;
        power_good_in = 4'h0;
        fault_in = 4'h0;
        repeat (10) @(posedge sys_clk);
        rst_n <= 1'b1;
        power_good_in <= 4'h5;
        foreach (rows[i]) begin
            host_port_model_i.write(rows[i].a, rows[i].d);
            rdchk(rows[i].a, rows[i].e);
        end
        check("vcode_a", vcode_a, 8'h3f);
        check("vcode_b", vcode_b, 8'h05);
        check("vcode_c", vcode_c, 8'h2a);
        check("vcode_d", vcode_d, 8'h3f);
        check("enable", regulator_enable, 8'h05);
        check("discharge", discharge_active, 8'h02);
        $display("test table done");
        // second reset in mid-run returns every field to zero and the interrupt source to all ones
        do_reset();
        power_good_in <= 4'h0;
        check("enable", regulator_enable, 8'h00);
        check("discharge", discharge_active, 8'h00);
        check("vcode_b", vcode_b, 8'h00);
        check("pending", interrupt_pending, 8'h00);
        rdchk(8'hc1, 8'hff);
        rdchk(8'h69, 8'h00);
        $display("test reset done");
        // power good follows the pin
        @(posedge sys_clk);
        power_good_in <= 4'h8;
        repeat (3) @(posedge sys_clk);
        rdchk(8'h91, 8'h01);
        rdchk(8'h69, 8'h00);
        $display("test power good done");
        // discharge only while shut down
        host_port_model_i.write(8'h69, 8'h04);
        repeat (2) @(posedge sys_clk);
        #1 check("discharge", discharge_active, 8'h01);
        host_port_model_i.write(8'h69, 8'h84);
        repeat (2) @(posedge sys_clk);
        #1 check("enable", regulator_enable, 8'h01);
        check("discharge", discharge_active, 8'h00);
        $display("test discharge done");
        // masked fault is dropped
        @(posedge sys_clk);
        fault_in <= 4'h2;
        repeat (6) @(posedge sys_clk);
        #1 check("pending", interrupt_pending, 8'h00);
        rdchk(8'hc1, 8'hff);
        // enabled fault loads the source, read returns it to idle
        host_port_model_i.write(8'h71, 8'h02);
        @(posedge sys_clk);
        fault_in <= 4'h0;
        repeat (3) @(posedge sys_clk);
        fault_in <= 4'h2;
        repeat (6) @(posedge sys_clk);
        #1 check("pending", interrupt_pending, 8'h01);
        rdchk(8'hc1, 8'h71);
        rdchk(8'hc1, 8'hff);
        check("pending", interrupt_pending, 8'h00);
        // three faults at once are served lowest regulator first
        host_port_model_i.write(8'h69, 8'h86);
        host_port_model_i.write(8'h81, 8'h02);
        host_port_model_i.write(8'h91, 8'h02);
        @(posedge sys_clk);
        fault_in <= 4'hf;
        repeat (6) @(posedge sys_clk);
        rdchk(8'hc1, 8'h69);
        rdchk(8'hc1, 8'h81);
        rdchk(8'hc1, 8'h91);
        rdchk(8'hc1, 8'hff);
        // source is read-only
        host_port_model_i.write(8'hc1, 8'h12);
        rdchk(8'hc1, 8'hff);
        $display("test interrupt source done");
        close_out();
    end
endmodule
